// ---- rcg_pkg.sv ----
// Package of offsets, fields, reset values and types for the port clock gating block
package rcg_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NUM_PORTS = 5;

  // ==========================================================================
  // Register offsets (byte addresses inside the control block)
  localparam logic [ADDR_W-1:0] OFS_RUN_GATE    = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_GATE  = 12'h118;
  localparam logic [ADDR_W-1:0] OFS_DEEP_GATE   = 12'h128;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_CFG   = 12'h060;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR   = 12'h204;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE  = 12'h208;
  localparam logic [ADDR_W-1:0] OFS_GATE_STATUS = 12'h20C;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_PORT_A      = 0;
  localparam int unsigned BIT_PORT_B      = 1;
  localparam int unsigned BIT_PORT_C      = 2;
  localparam int unsigned BIT_PORT_D      = 3;
  localparam int unsigned BIT_PORT_E      = 4;
  localparam int unsigned BIT_AUTO_GATING = 27;
  localparam int unsigned POS_MODE_FIELD  = 8;

  // ==========================================================================
  // Reset values
  localparam logic [NUM_PORTS-1:0] GATE_RESET = 5'h00;
  localparam logic [DATA_W-1:0]    REG_RESET  = 32'h00000000;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Power modes, one-hot
  typedef enum logic [2:0] {
    MODE_RUN   = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_DEEP  = 3'h4
  } rcg_mode_type;

  // ==========================================================================
  // Main state
  typedef struct packed {
    logic                  aw_full;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_full;
    logic [DATA_W-1:0]     w_data;
    logic [3:0]            w_strb;
    logic                  b_valid;
    logic [1:0]            b_resp;
    logic                  r_valid;
    logic [DATA_W-1:0]     r_data;
    logic [1:0]            r_resp;
    logic [NUM_PORTS-1:0]  run_gate;
    logic [NUM_PORTS-1:0]  sleep_gate;
    logic [NUM_PORTS-1:0]  deep_gate;
    logic                  auto_gating;
    logic [NUM_PORTS-1:0]  irq_status;
    logic [NUM_PORTS-1:0]  irq_enable;
    rcg_mode_type          mode;
    logic [NUM_PORTS-1:0]  port_enable;
  } rcg_main_state_type;

  // Access guard state
  typedef struct packed {
    logic                  ack;
    logic                  fault;
    logic [NUM_PORTS-1:0]  fault_event;
  } rcg_guard_state_type;

endpackage

// ---- rcg_gate_if.sv ----
// Interface between the gating control and the port access guard
`timescale 1ns/1ps
interface rcg_gate_if #(parameter int unsigned NUM_PORTS = 5);
  logic [NUM_PORTS-1:0] port_enable;
  logic [NUM_PORTS-1:0] fault_event;

  modport ctrl  (output port_enable, input fault_event);
  modport guard (input port_enable, output fault_event);
endinterface

// ---- rcg_clock_gate.sv ----
// Glitch-free clock gating cell, latch transparent while the clock is low
`timescale 1ns/1ps
module rcg_clock_gate (
  // Clock and enable
  input  wire logic i_mclk,
  input  wire logic i_enable,
  // Gated clock
  output wire logic o_gclk
);

  logic enable_latch;

  // ==========================================================================
  // Enable only changes while clock is low, so no runt pulse on the gated clock
  always_latch begin
    if (!i_mclk) begin
      enable_latch <= i_enable;
    end
  end

  assign o_gclk = i_mclk & enable_latch;

endmodule

// ---- rcg_access_guard.sv ----
// Guard that faults port accesses aimed at an unclocked port
`timescale 1ns/1ps
module rcg_access_guard
  import rcg_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  input  wire logic                 i_ce,
  // Port-side access request
  input  wire logic                 i_port_req,
  input  wire logic [2:0]           i_port_sel,
  // Access answer
  output wire logic                 o_port_ack,
  output wire logic                 o_port_fault,
  // Enables in, fault events out
  rcg_gate_if.guard                 gate
);

  rcg_guard_state_type s;
  rcg_guard_state_type next_s;

  // ==========================================================================
  // Answer one cycle after the request; unknown port index also faults
  always_comb begin
    next_s             = s;
    next_s.ack         = i_port_req;
    next_s.fault       = 1'b0;
    next_s.fault_event = '0;
    if (i_port_req) begin
      if (i_port_sel >= 3'(NUM_PORTS)) begin
        next_s.fault = 1'b1;
      end else if (!gate.port_enable[i_port_sel]) begin
        next_s.fault = 1'b1;
        next_s.fault_event[i_port_sel] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_port_ack       = s.ack;
  assign o_port_fault     = s.fault;
  assign gate.fault_event = s.fault_event;

endmodule

// ---- rcg_port_clock_ctrl.sv ----
// Run-mode port clock gating control with AXI4-Lite register access
`timescale 1ns/1ps
module rcg_port_clock_ctrl
  import rcg_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
) (
  // Clock, reset, enable
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  input  wire logic                 i_ce,
  // AXI4-Lite write address
  input  wire logic                 i_awvalid,
  output wire logic                 o_awready,
  input  wire logic [ADDR_W-1:0]    i_awaddr,
  // AXI4-Lite write data
  input  wire logic                 i_wvalid,
  output wire logic                 o_wready,
  input  wire logic [DATA_W-1:0]    i_wdata,
  input  wire logic [3:0]           i_wstrb,
  // AXI4-Lite write response
  output wire logic                 o_bvalid,
  input  wire logic                 i_bready,
  output wire logic [1:0]           o_bresp,
  // AXI4-Lite read address
  input  wire logic                 i_arvalid,
  output wire logic                 o_arready,
  input  wire logic [ADDR_W-1:0]    i_araddr,
  // AXI4-Lite read data
  output wire logic                 o_rvalid,
  input  wire logic                 i_rready,
  output wire logic [DATA_W-1:0]    o_rdata,
  output wire logic [1:0]           o_rresp,
  // Power state requests
  input  wire logic                 i_sleep,
  input  wire logic                 i_deep_sleep,
  // Port-side access
  input  wire logic                 i_port_req,
  input  wire logic [2:0]           i_port_sel,
  output wire logic                 o_port_ack,
  output wire logic                 o_port_fault,
  // Gated port clocks and enables
  output wire logic [PORTS-1:0]     o_port_clk,
  output wire logic [PORTS-1:0]     o_port_enable,
  // Interrupt
  output wire logic                 o_irq
);

  rcg_main_state_type s;
  rcg_main_state_type next_s;

  rcg_gate_if #(.NUM_PORTS(NUM_PORTS)) gate ();

  logic                 aw_take;
  logic                 w_take;
  logic                 ar_take;
  logic                 do_write;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic [3:0]           wr_strb;

  // ==========================================================================
  // Handshake; ready drops while frozen so no transfer is lost
  assign o_awready = i_ce & ~s.aw_full & ~s.b_valid;
  assign o_wready  = i_ce & ~s.w_full & ~s.b_valid;
  assign o_arready = i_ce & ~s.r_valid;
  assign aw_take   = i_awvalid & o_awready;
  assign w_take    = i_wvalid & o_wready;
  assign ar_take   = i_arvalid & o_arready;

  // Address and data may arrive in either order
  assign wr_addr  = s.aw_full ? s.aw_addr : i_awaddr;
  assign wr_data  = s.w_full ? s.w_data : i_wdata;
  assign wr_strb  = s.w_full ? s.w_strb : i_wstrb;
  assign do_write = (s.aw_full | aw_take) & (s.w_full | w_take);

  // ==========================================================================
  // Address decode
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      OFS_RUN_GATE, OFS_SLEEP_GATE, OFS_DEEP_GATE, OFS_CLOCK_CFG,
      OFS_IRQ_STATUS, OFS_IRQ_CLEAR, OFS_IRQ_ENABLE, OFS_GATE_STATUS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ==========================================================================
  // Read mux; reserved bits and write-only registers read zero
  function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] addr,
                                                   input rcg_main_state_type st);
    logic [DATA_W-1:0] val;
    val = REG_RESET;
    case (addr)
      OFS_RUN_GATE: begin
        val[NUM_PORTS-1:0] = st.run_gate;
      end
      OFS_SLEEP_GATE: begin
        val[NUM_PORTS-1:0] = st.sleep_gate;
      end
      OFS_DEEP_GATE: begin
        val[NUM_PORTS-1:0] = st.deep_gate;
      end
      OFS_CLOCK_CFG: begin
        val[BIT_AUTO_GATING] = st.auto_gating;
      end
      OFS_IRQ_STATUS: begin
        val[NUM_PORTS-1:0] = st.irq_status;
      end
      OFS_IRQ_ENABLE: begin
        val[NUM_PORTS-1:0] = st.irq_enable;
      end
      OFS_GATE_STATUS: begin
        val[NUM_PORTS-1:0] = st.port_enable;
        val[POS_MODE_FIELD +: 3] = st.mode;
      end
      default: begin
        val = REG_RESET;
      end
    endcase
    return val;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;

    // Write channel capture
    if (aw_take && !do_write) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = i_awaddr;
    end
    if (w_take && !do_write) begin
      next_s.w_full = 1'b1;
      next_s.w_data = i_wdata;
      next_s.w_strb = i_wstrb;
    end
    if (s.b_valid && i_bready) begin
      next_s.b_valid = 1'b0;
    end

    // Fault events set sticky status bits
    next_s.irq_status = s.irq_status;

    // Register write; only byte lane 0 holds the gating bits
    if (do_write) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.b_valid = 1'b1;
      next_s.b_resp  = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      case (wr_addr)
        OFS_RUN_GATE: begin
          if (wr_strb[0]) begin
            next_s.run_gate = wr_data[NUM_PORTS-1:0];
          end
        end
        OFS_SLEEP_GATE: begin
          if (wr_strb[0]) begin
            next_s.sleep_gate = wr_data[NUM_PORTS-1:0];
          end
        end
        OFS_DEEP_GATE: begin
          if (wr_strb[0]) begin
            next_s.deep_gate = wr_data[NUM_PORTS-1:0];
          end
        end
        OFS_CLOCK_CFG: begin
          if (wr_strb[BIT_AUTO_GATING / 8]) begin
            next_s.auto_gating = wr_data[BIT_AUTO_GATING];
          end
        end
        OFS_IRQ_CLEAR: begin
          if (wr_strb[0]) begin
            next_s.irq_status = s.irq_status & ~wr_data[NUM_PORTS-1:0];
          end
        end
        OFS_IRQ_ENABLE: begin
          if (wr_strb[0]) begin
            next_s.irq_enable = wr_data[NUM_PORTS-1:0];
          end
        end
        default: begin
          next_s.b_resp = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    next_s.irq_status = next_s.irq_status | gate.fault_event;

    // Read channel
    if (s.r_valid && i_rready) begin
      next_s.r_valid = 1'b0;
    end
    if (ar_take) begin
      next_s.r_valid = 1'b1;
      next_s.r_data  = read_value(i_araddr, s);
      next_s.r_resp  = is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Power mode; sleep sets only count with auto gating selected
    if (s.auto_gating && i_deep_sleep) begin
      next_s.mode = MODE_DEEP;
    end else if (s.auto_gating && i_sleep) begin
      next_s.mode = MODE_SLEEP;
    end else begin
      next_s.mode = MODE_RUN;
    end

    // Enable set follows the mode, registered to keep it glitch-free
    case (next_s.mode)
      MODE_RUN: begin
        next_s.port_enable = next_s.run_gate;
      end
      MODE_SLEEP: begin
        next_s.port_enable = next_s.sleep_gate;
      end
      MODE_DEEP: begin
        next_s.port_enable = next_s.deep_gate;
      end
      default: begin
        next_s.port_enable = next_s.run_gate;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s             <= '0;
      s.run_gate    <= GATE_RESET;
      s.sleep_gate  <= GATE_RESET;
      s.deep_gate   <= GATE_RESET;
      s.port_enable <= GATE_RESET;
      s.mode        <= MODE_RUN;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // One gating cell per port
  assign gate.port_enable = s.port_enable;

  for (genvar g = 0; g < PORTS; g++) begin : gen_gate
    rcg_clock_gate u_gate (
      .i_mclk   (i_mclk),
      .i_enable (s.port_enable[g]),
      .o_gclk   (o_port_clk[g])
    );
  end

  // ==========================================================================
  // Access guard
  rcg_access_guard u_guard (
    .i_mclk       (i_mclk),
    .i_reset      (i_reset),
    .i_ce         (i_ce),
    .i_port_req   (i_port_req),
    .i_port_sel   (i_port_sel),
    .o_port_ack   (o_port_ack),
    .o_port_fault (o_port_fault),
    .gate         (gate.guard)
  );

  // ==========================================================================
  // Outputs
  assign o_bvalid      = s.b_valid;
  assign o_bresp       = s.b_resp;
  assign o_rvalid      = s.r_valid;
  assign o_rdata       = s.r_data;
  assign o_rresp       = s.r_resp;
  assign o_port_enable = s.port_enable;
  assign o_irq         = |(s.irq_status & s.irq_enable);

endmodule

// ---- rcg_props.sv ----
// Checker of the port clock gating block's port behaviour
`timescale 1ns/1ps
module rcg_props
  import rcg_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
) (
  // Clock, reset, enable
  input wire logic              i_mclk,
  input wire logic              i_reset,
  input wire logic              i_ce,
  // Register bus
  input wire logic              o_bvalid,
  input wire logic              i_bready,
  input wire logic [1:0]        o_bresp,
  input wire logic              i_arvalid,
  input wire logic              o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic              o_rvalid,
  input wire logic              i_rready,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [1:0]        o_rresp,
  // Port access and clocks
  input wire logic              i_port_req,
  input wire logic [2:0]        i_port_sel,
  input wire logic              o_port_ack,
  input wire logic              o_port_fault,
  input wire logic [PORTS-1:0]  o_port_clk,
  input wire logic [PORTS-1:0]  o_port_enable
);
  // ==========================================================================
  // Helpers
  logic [ADDR_W-1:0] rd_addr;
  logic              sel_on;

  // Guard first, an out-of-range index reads x
  assign sel_on = (i_port_sel < 3'h5) && o_port_enable[i_port_sel];

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rd_addr <= '0;
    end else if (i_arvalid && o_arready) begin
      rd_addr <= i_araddr;
    end
  end

  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  // ==========================================================================
  // Properties
  sequence s_fault_req;
    i_port_req && i_ce && !sel_on;
  endsequence
  sequence s_fault_answer;
    ##1 o_port_ack && o_port_fault;
  endsequence

  a_fault_disabled: assert property (s_fault_req |-> s_fault_answer)
    else $error("Access to unclocked port not faulted");
  a_ack_enabled: assert property (i_port_req && i_ce && sel_on |=> o_port_ack && !o_port_fault)
    else $error("Access to clocked port not answered cleanly");
  a_ack_single: assert property (i_ce && !i_port_req |=> !o_port_ack)
    else $error("Port answer without request");
  // Latch holds the pre-edge enable through the high phase
  a_clock_gated: assert property (@(negedge i_mclk) disable iff (i_reset)
    o_port_clk == $past(o_port_enable))
    else $error("Gated clock does not follow enable");
  a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("Write response dropped early");
  a_rdata_stands: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("Read data dropped early");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("Read not answered next cycle");
  a_reserved_zero: assert property (o_rvalid && rd_addr == OFS_RUN_GATE |->
    o_rdata[31:5] == 27'h0 && o_rresp == RESP_OKAY)
    else $error("Gating register read bad");
endmodule

bind rcg_port_clock_ctrl rcg_props #(.PORTS(PORTS)) u_props (
  .i_mclk, .i_reset, .i_ce, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
  .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_port_req, .i_port_sel, .o_port_ack, .o_port_fault,
  .o_port_clk, .o_port_enable
);

// ---- run_mode_port_clock_gating_tb_top.sv ----
// Self-checking testbench of the port clock gating block
`timescale 1ns/1ps
module run_mode_port_clock_gating_tb_top
  import rcg_pkg::*;
;
  // ==========================================================================
  // Signals
  logic              i_mclk = 1'b0;
  logic              i_reset, i_ce, i_awvalid, i_wvalid, i_bready;
  logic              i_arvalid, i_rready, i_sleep, i_deep_sleep, i_port_req;
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic [DATA_W-1:0] i_wdata, o_rdata, rd;
  logic [3:0]        i_wstrb;
  logic [2:0]        i_port_sel;
  logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic              o_port_ack, o_port_fault, o_irq;
  logic [1:0]        o_bresp, o_rresp;
  logic [4:0]        o_port_clk, o_port_enable;
  int                failures, total_checks;

  rcg_port_clock_ctrl DUT (
    .i_mclk, .i_reset, .i_ce, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp, .i_sleep, .i_deep_sleep, .i_port_req, .i_port_sel,
    .o_port_ack, .o_port_fault, .o_port_clk, .o_port_enable, .o_irq
  );

  always #2 i_mclk = ~i_mclk;

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_mclk);
      if (!aw_ok && o_awready) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w_ok && o_wready) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_mclk); while (!o_bvalid);
    check(o_bresp, er);
    i_bready <= 1'b0;
    // An edge passes so a following call never re-raises bready in this step
    @(posedge i_mclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [1:0] er);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do @(posedge i_mclk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_mclk); while (!o_rvalid);
    rd = o_rdata;
    check(o_rresp, er);
    i_rready <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic port_req(input logic [2:0] s, input logic ef);
    i_port_req <= 1'b1;
    i_port_sel <= s;
    tick(1);
    i_port_req <= 1'b0;
    tick(1);
    check(o_port_ack, 1'b1);
    check(o_port_fault, ef);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    i_reset <= 1'b1;
    tick(3);
    i_reset <= 1'b0;
    tick(1);
    check(o_port_enable, 5'h00);
    check(o_irq, 1'b0);
    rdc(OFS_RUN_GATE, RESP_OKAY);
    check(rd, REG_RESET);
  endtask

  // One port at a time, reserved bits written as ones
  task automatic t_bits;
    for (int i = 0; i < 5; i++) begin
      wr(OFS_RUN_GATE, 32'hFFFFFFE0 | (32'h1 << i), RESP_OKAY);
      rdc(OFS_RUN_GATE, RESP_OKAY);
      check(rd, 32'h1 << i);
      tick(2);
      check(o_port_enable, 5'h01 << i);
      for (int s = 0; s < 8; s++) begin
        port_req(s[2:0], s != i);
      end
    end
  endtask

  task automatic t_clocks;
    wr(OFS_RUN_GATE, 32'h15, RESP_OKAY);
    tick(2);
    @(negedge i_mclk);
    #1;
    check(o_port_clk, 5'h00);
    #2;
    check(o_port_clk, 5'h15);
    tick(1);
  endtask

  // The port sweep left status bits set; start from a clean status
  task automatic t_irq;
    wr(OFS_IRQ_CLEAR, 32'h1F, RESP_OKAY);
    rdc(OFS_IRQ_STATUS, RESP_OKAY);
    check(rd, 32'h0);
    wr(OFS_RUN_GATE, 32'h1, RESP_OKAY);
    wr(OFS_IRQ_ENABLE, 32'h4, RESP_OKAY);
    port_req(3'h1, 1'b1);
    tick(1);
    check(o_irq, 1'b0);
    port_req(3'h2, 1'b1);
    tick(1);
    check(o_irq, 1'b1);
    rdc(OFS_IRQ_STATUS, RESP_OKAY);
    check(rd, 32'h6);
    wr(OFS_IRQ_CLEAR, 32'h4, RESP_OKAY);
    tick(1);
    check(o_irq, 1'b0);
    rdc(OFS_IRQ_CLEAR, RESP_OKAY);
    check(rd, 32'h0);
    rdc(OFS_IRQ_STATUS, RESP_OKAY);
    check(rd, 32'h2);
  endtask

  // Unmapped places fault and leave the gating register alone
  task automatic t_unmapped;
    wr(12'h10C, 32'h1F, RESP_SLVERR);
    rdc(12'h300, RESP_SLVERR);
    rdc(OFS_RUN_GATE, RESP_OKAY);
    check(rd, 32'h1);
  endtask

  // Frozen block takes no port request and offers no read slot
  task automatic t_freeze;
    i_ce <= 1'b0;
    i_port_req <= 1'b1;
    i_port_sel <= 3'h4;
    tick(1);
    i_port_req <= 1'b0;
    tick(1);
    check(o_port_ack, 1'b0);
    check(o_arready, 1'b0);
    i_ce <= 1'b1;
    tick(1);
  endtask

  task automatic t_modes;
    wr(OFS_RUN_GATE, 32'h03, RESP_OKAY);
    wr(OFS_SLEEP_GATE, 32'h0C, RESP_OKAY);
    wr(OFS_DEEP_GATE, 32'h10, RESP_OKAY);
    i_sleep <= 1'b1;
    tick(3);
    check(o_port_enable, 5'h03);
    wr(OFS_CLOCK_CFG, 32'h1 << BIT_AUTO_GATING, RESP_OKAY);
    tick(3);
    check(o_port_enable, 5'h0C);
    rdc(OFS_GATE_STATUS, RESP_OKAY);
    check(rd, (32'(MODE_SLEEP) << POS_MODE_FIELD) | 32'h0C);
    i_deep_sleep <= 1'b1;
    tick(3);
    check(o_port_enable, 5'h10);
    i_sleep <= 1'b0;
    i_deep_sleep <= 1'b0;
    tick(3);
    check(o_port_enable, 5'h03);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_sleep, i_deep_sleep, i_port_req, i_awaddr, i_araddr, i_wdata, i_wstrb, i_port_sel} = '0;
    i_ce = 1'b1;
    failures = 0;
    total_checks = 0;
    t_reset();
    t_bits();
    t_clocks();
    t_irq();
    t_unmapped();
    t_freeze();
    t_modes();
    // Second reset in mid-run with ports enabled
    t_reset();
    results();
  end

  // Whole run takes a few hundred cycles
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule
